// file: rtl/chain_defs.vh
// Constants for the daisy-chain controller and path selector
// Behaviour
// RL1 - Chain holds at most 25 modules
// RL2 - Host-attached module takes address zero, master
// RL3 - Slaves numbered one upward in order, to 24
// RL4 - Addresses assigned automatically during enumeration
// RL5 - Only master talks to host; forwards downstream
// RL6 - Serial out feeds next module's serial in
// RL7 - New module joins on refresh, no reset
// RL8 - State 0 open, 1 com-to-1, 2 com-to-2
// RL9 - Invalid state codes ignored, path kept
`ifndef CHAIN_DEFS_VH
`define CHAIN_DEFS_VH
`define CHAIN_MAX_MODULES 25
`define CHAIN_MASTER_ADDR 5'h00
`define CHAIN_LAST_ADDR 5'h18
`define CHAIN_UNASSIGNED 5'h1f
`define FRAME_BITS 16
`define OP_ASSIGN 3'h1
`define OP_SET_PATH 3'h2
`define PATH_OPEN 2'h0
`define PATH_TO_1 2'h1
`define PATH_TO_2 2'h2
`define BIT_TIME_NS 1000
`define CLK_PERIOD_NS 50
`define BIT_CYCLES ((`BIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: rtl/path_decode.v
// RF path decoder holding the current switch state
`timescale 1ns/1ps
`include "chain_defs.vh"
module path_decode (
    input wire core_clk,
    input wire rstn,
    input wire load,
    input wire [1:0] code,
    output reg sel_1,
    output reg sel_2,
    output reg term_1,
    output reg term_2,
    output reg [1:0] state_r
);
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= `PATH_OPEN;
        end else if (load && (code <= `PATH_TO_2)) begin
            state_r <= code; // RL9
        end
    end
    // Unselected port is always terminated to stay absorptive
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sel_1 <= 1'b0;
            sel_2 <= 1'b0;
            term_1 <= 1'b1;
            term_2 <= 1'b1;
        end else begin
            sel_1 <= (state_r == `PATH_TO_1); // RL8
            sel_2 <= (state_r == `PATH_TO_2); // RL8
            term_1 <= (state_r != `PATH_TO_1); // RL8
            term_2 <= (state_r != `PATH_TO_2); // RL8
        end
    end
endmodule

// file: rtl/chain_ctrl.v
// Daisy-chain address assignment, command forwarding and path select
`timescale 1ns/1ps
`include "chain_defs.vh"
module chain_ctrl #(
    parameter MAX_MODULES = `CHAIN_MAX_MODULES,
    parameter BIT_CYCLES = `BIT_CYCLES
) (
    input wire core_clk,
    input wire rstn,
    input wire host_attached,
    input wire host_valid,
    input wire [2:0] host_op,
    input wire [4:0] host_addr,
    input wire [1:0] host_code,
    output wire host_ready,
    output reg assign_done_r,
    output reg [4:0] chain_count_r,
    input wire ser_in,
    output reg ser_out_r,
    output reg [4:0] my_addr_r,
    output reg is_master_r,
    output wire sel_1,
    output wire sel_2,
    output wire term_1,
    output wire term_2,
    output wire [1:0] path_state
);
    // Frame: start bit 0, op[2:0], addr[4:0], code[1:0], pad[4:0], MSB first; line idles high.
    localparam TX_IDLE = 2'b01;
    localparam TX_SEND = 2'b10;
    localparam RX_IDLE = 2'b01;
    localparam RX_RECV = 2'b10;
    localparam [31:0] LAST_WIDE = MAX_MODULES - 1;
    localparam [4:0] LAST_ADDR = LAST_WIDE[4:0];

    ////////////////////////////////////////////////////////////////////////
    // Receiver on serial in, used only as slave
    reg [1:0] rx_st_r;
    reg [7:0] rx_cnt_r;
    reg [4:0] rx_bit_r;
    reg [15:0] rx_sh_r;
    reg rx_done_r;
    reg ser_in_q_r;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_st_r <= RX_IDLE;
            rx_cnt_r <= 8'h00;
            rx_bit_r <= 5'h00;
            rx_sh_r <= 16'h0000;
            rx_done_r <= 1'b0;
            ser_in_q_r <= 1'b1;
        end else begin
            rx_done_r <= 1'b0;
            ser_in_q_r <= ser_in;
            case (rx_st_r)
                RX_IDLE: begin
                    // Start needs a falling edge; a trailing zero pad bit would otherwise restart
                    if (ser_in_q_r && !ser_in && !is_master_r) begin
                        rx_st_r <= RX_RECV;
                        rx_cnt_r <= 8'h00;
                        rx_bit_r <= 5'h00;
                    end
                end
                RX_RECV: begin
                    // Sample mid-bit; first half-bit offset comes from the start edge
                    if (rx_cnt_r == BIT_CYCLES[7:0] - 8'h01) begin
                        rx_cnt_r <= 8'h00;
                    end else begin
                        rx_cnt_r <= rx_cnt_r + 8'h01;
                    end
                    if (rx_cnt_r == BIT_CYCLES[7:0] / 8'h02) begin
                        rx_sh_r <= {rx_sh_r[14:0], ser_in};
                        if (rx_bit_r == `FRAME_BITS - 1) begin
                            rx_done_r <= 1'b1;
                            rx_st_r <= RX_IDLE;
                        end
                        rx_bit_r <= rx_bit_r + 5'h01;
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end
    wire [2:0] rx_op = rx_sh_r[14:12];
    wire [4:0] rx_addr = rx_sh_r[11:7];
    wire [1:0] rx_code = rx_sh_r[6:5];

    ////////////////////////////////////////////////////////////////////////
    // Transmitter on serial out
    reg [1:0] tx_st_r;
    reg [7:0] tx_cnt_r;
    reg [4:0] tx_bit_r;
    reg [15:0] tx_sh_r;
    reg tx_req;
    reg [15:0] tx_frame;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_st_r <= TX_IDLE;
            tx_cnt_r <= 8'h00;
            tx_bit_r <= 5'h00;
            tx_sh_r <= 16'hffff;
            ser_out_r <= 1'b1;
        end else begin
            case (tx_st_r)
                TX_IDLE: begin
                    ser_out_r <= 1'b1;
                    if (tx_req) begin
                        tx_st_r <= TX_SEND;
                        tx_sh_r <= {tx_frame[14:0], 1'b1};
                        ser_out_r <= tx_frame[15]; // RL6
                        tx_cnt_r <= 8'h00;
                        tx_bit_r <= 5'h00;
                    end
                end
                TX_SEND: begin
                    if (tx_cnt_r == BIT_CYCLES[7:0] - 8'h01) begin
                        tx_cnt_r <= 8'h00;
                        if (tx_bit_r == `FRAME_BITS - 1) begin
                            tx_st_r <= TX_IDLE;
                            ser_out_r <= 1'b1;
                        end else begin
                            ser_out_r <= tx_sh_r[15]; // RL6
                            tx_sh_r <= {tx_sh_r[14:0], 1'b1};
                        end
                        tx_bit_r <= tx_bit_r + 5'h01;
                    end else begin
                        tx_cnt_r <= tx_cnt_r + 8'h01;
                    end
                end
                default: tx_st_r <= TX_IDLE;
            endcase
        end
    end
    wire tx_free = (tx_st_r == TX_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Role, address and command routing
    assign host_ready = is_master_r && tx_free; // RL5
    wire host_take = host_valid && host_ready;
    reg path_load;
    reg [1:0] path_code;
    always @* begin
        tx_req = 1'b0;
        tx_frame = 16'hffff;
        path_load = 1'b0;
        path_code = `PATH_OPEN;
        if (host_take) begin
            if (host_op == `OP_ASSIGN) begin
                // Master opens enumeration by offering the first slave address
                tx_req = 1'b1; // RL4
                tx_frame = {1'b0, `OP_ASSIGN, 5'h01, 2'h0, 5'h00}; // RL3
            end else if (host_op == `OP_SET_PATH) begin
                if (host_addr == `CHAIN_MASTER_ADDR) begin
                    path_load = 1'b1;
                    path_code = host_code;
                end else if (host_addr <= LAST_ADDR) begin
                    tx_req = 1'b1; // RL5
                    tx_frame = {1'b0, `OP_SET_PATH, host_addr, host_code, 5'h00};
                end
            end
        end else if (rx_done_r && !is_master_r && tx_free) begin
            if (rx_op == `OP_ASSIGN) begin
                // Passing on the next address; stops after the last legal slot
                if (rx_addr < LAST_ADDR) begin
                    tx_req = 1'b1; // RL1
                    tx_frame = {1'b0, `OP_ASSIGN, rx_addr + 5'h01, 2'h0, 5'h00}; // RL3
                end
            end else if (rx_op == `OP_SET_PATH) begin
                if (rx_addr == my_addr_r) begin
                    path_load = 1'b1;
                    path_code = rx_code;
                end else begin
                    tx_req = 1'b1; // RL6
                    tx_frame = rx_sh_r;
                end
            end
        end
    end

    // Address and count are rewritten on every refresh; path state is untouched
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            my_addr_r <= `CHAIN_UNASSIGNED;
            is_master_r <= 1'b0;
            assign_done_r <= 1'b0;
            chain_count_r <= 5'h01;
        end else begin
            assign_done_r <= 1'b0;
            if (host_attached) begin
                is_master_r <= 1'b1; // RL2
                my_addr_r <= `CHAIN_MASTER_ADDR; // RL2
            end else begin
                is_master_r <= 1'b0;
                if (rx_done_r && rx_op == `OP_ASSIGN && rx_addr <= LAST_ADDR) begin
                    my_addr_r <= rx_addr; // RL7
                end
            end
            if (host_take && host_op == `OP_ASSIGN) begin
                chain_count_r <= 5'h01; // RL7
                assign_done_r <= 1'b1; // RL4
            end
        end
    end

    path_decode u_path (
        .core_clk(core_clk),
        .rstn(rstn),
        .load(path_load),
        .code(path_code),
        .sel_1(sel_1),
        .sel_2(sel_2),
        .term_1(term_1),
        .term_2(term_2),
        .state_r(path_state)
    );
endmodule

// file: test/chain_ctrl_monitor.sv
// Port assertions for the chain controller
`timescale 1ns/1ps
module chain_ctrl_monitor (
    input wire core_clk,
    input wire rstn,
    input wire host_valid,
    input wire [2:0] host_op,
    input wire [4:0] host_addr,
    input wire [1:0] host_code,
    input wire host_ready,
    input wire assign_done_r,
    input wire ser_out_r,
    input wire [4:0] my_addr_r,
    input wire is_master_r,
    input wire sel_1,
    input wire sel_2,
    input wire term_1,
    input wire term_2,
    input wire [1:0] path_state
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (!rstn);
wire take = host_valid && host_ready;
////////////////////////////////////////
property p_master_addr; is_master_r |-> my_addr_r == 5'h00; endproperty
a_master_addr: assert property (p_master_addr) else $error("master address not zero");
property p_addr_range; my_addr_r <= 5'h18 || my_addr_r == 5'h1f; endproperty
a_addr_range: assert property (p_addr_range) else $error("address beyond chain");
property p_ready_master; host_ready |-> is_master_r; endproperty
a_ready_master: assert property (p_ready_master) else $error("slave accepted host");
property p_path_set; take && host_op == 3'h2 && host_addr == 5'h00 && host_code != 2'h3 |=> path_state == $past(host_code); endproperty
a_path_set: assert property (p_path_set) else $error("path code not taken");
property p_bad_code; take && host_code == 2'h3 |=> $stable(path_state); endproperty
a_bad_code: assert property (p_bad_code) else $error("invalid code changed path");
property p_state1; path_state == 2'h1 |=> sel_1 && !sel_2 && !term_1 && term_2; endproperty
a_state1: assert property (p_state1) else $error("state 1 ports wrong");
property p_state2; path_state == 2'h2 |=> sel_2 && !sel_1 && term_1 && !term_2; endproperty
a_state2: assert property (p_state2) else $error("state 2 ports wrong");
property p_state0; path_state == 2'h0 |=> !sel_1 && !sel_2 && term_1 && term_2; endproperty
a_state0: assert property (p_state0) else $error("state 0 ports wrong");
property p_forward; take && host_op == 3'h2 && host_addr != 5'h00 && host_addr <= 5'h18 |=> !ser_out_r && $stable(path_state); endproperty
a_forward: assert property (p_forward) else $error("slave command not forwarded");
property p_refresh; take && host_op == 3'h1 |-> ##[0:1] assign_done_r; endproperty
a_refresh: assert property (p_refresh) else $error("refresh not taken");
property p_busy; !ser_out_r |-> !host_ready; endproperty
a_busy: assert property (p_busy) else $error("ready while sending");
endmodule
bind chain_ctrl chain_ctrl_monitor u_mon (.core_clk(core_clk), .rstn(rstn), .host_valid(host_valid),
    .host_op(host_op), .host_addr(host_addr), .host_code(host_code), .host_ready(host_ready),
    .assign_done_r(assign_done_r), .ser_out_r(ser_out_r), .my_addr_r(my_addr_r), .is_master_r(is_master_r),
    .sel_1(sel_1), .sel_2(sel_2), .term_1(term_1), .term_2(term_2), .path_state(path_state));

// file: test/chain_peer.sv
// Downstream module model receiving chain frames
`timescale 1ns/1ps
module chain_peer #(parameter BIT_CYCLES = 4) (
    input wire core_clk,
    input wire ser_line,
    output reg [15:0] rx_frame,
    output reg [7:0] rx_count
);
reg [15:0] sh;
integer i;
////////////////////////////////////////
initial begin
    rx_frame = 16'h0000;
    rx_count = 8'h00;
    sh = 16'h0000;
    forever begin
        @(negedge ser_line);
        // Mid-bit sampling tolerates start edge phase
        repeat (BIT_CYCLES / 2) @(negedge core_clk);
        for (i = 0; i < 16; i = i + 1) begin
            sh = {sh[14:0], ser_line};
            if (i < 15) repeat (BIT_CYCLES) @(negedge core_clk);
        end
        rx_frame = sh;
        rx_count = rx_count + 8'h01;
    end
end
endmodule

// file: test/tb_chain_ctrl.sv
// Self-checking bench for the chain controller
`timescale 1ns/1ps
module tb_chain_ctrl;
reg core_clk = 1'b0;
reg rstn = 1'b0;
reg host_valid = 1'b0;
reg [2:0] host_op = 3'h0;
reg [4:0] host_addr = 5'h00;
reg [1:0] host_code = 2'h0;
wire host_ready, assign_done_r, ser_out_r, is_master_r, sel_1, sel_2, term_1, term_2;
wire [4:0] chain_count_r, my_addr_r;
wire [1:0] path_state;
wire [15:0] rx_frame;
wire [7:0] rx_count;
wire s_ready, s_ser, s_master;
wire [4:0] s_addr;
wire [1:0] s_path;
reg linked = 1'b0;
// Slave sees an idle line until linked, standing in for a module plugged in later
wire slave_in = linked ? ser_out_r : 1'b1;
integer n_errors = 0;
integer samples_checked = 0;
integer cycles = 0;
chain_ctrl #(.BIT_CYCLES(4)) u_dut (.core_clk(core_clk), .rstn(rstn), .host_attached(1'b1),
    .host_valid(host_valid), .host_op(host_op), .host_addr(host_addr), .host_code(host_code),
    .host_ready(host_ready), .assign_done_r(assign_done_r), .chain_count_r(chain_count_r), .ser_in(1'b1),
    .ser_out_r(ser_out_r), .my_addr_r(my_addr_r), .is_master_r(is_master_r), .sel_1(sel_1), .sel_2(sel_2),
    .term_1(term_1), .term_2(term_2), .path_state(path_state));
chain_ctrl #(.BIT_CYCLES(4)) u_slave (.core_clk(core_clk), .rstn(rstn), .host_attached(1'b0),
    .host_valid(host_valid), .host_op(host_op), .host_addr(host_addr), .host_code(host_code),
    .host_ready(s_ready), .assign_done_r(), .chain_count_r(), .ser_in(slave_in),
    .ser_out_r(s_ser), .my_addr_r(s_addr), .is_master_r(s_master), .sel_1(), .sel_2(),
    .term_1(), .term_2(), .path_state(s_path));
chain_peer #(.BIT_CYCLES(4)) u_peer (.core_clk(core_clk), .ser_line(s_ser), .rx_frame(rx_frame),
    .rx_count(rx_count));
////////////////////////////////////////
initial forever #25 core_clk = ~core_clk;
always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
        n_errors = n_errors + 1;
        report_and_stop;
    end
end
task report_and_stop;
    begin
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    end
endtask
task check(input string name, input [15:0] seen, input [15:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    end
endtask
task send(input [2:0] op, input [4:0] addr, input [1:0] code);
    integer i;
    begin
        i = 0;
        @(negedge core_clk);
        while (host_ready !== 1'b1 && i < 300) begin
            @(negedge core_clk);
            i = i + 1;
        end
        @(posedge core_clk);
        host_valid <= 1'b1;
        host_op <= op;
        host_addr <= addr;
        host_code <= code;
        @(posedge core_clk);
        host_valid <= 1'b0;
    end
endtask
task wait_frame(input [7:0] n);
    integer i;
    begin
        i = 0;
        while (rx_count !== n && i < 300) begin
            @(negedge core_clk);
            i = i + 1;
        end
        check("frames", rx_count, n);
    end
endtask
////////////////////////////////////////
task t_paths;
    integer i;
    reg [1:0] c, st;
    begin
        st = 2'h0;
        for (i = 0; i < 4; i = i + 1) begin
            c = (i == 0) ? 2'h1 : (i == 1) ? 2'h3 : (i == 2) ? 2'h2 : 2'h0;
            send(3'h2, 5'h00, c);
            if (c != 2'h3) st = c;
            repeat (3) @(negedge core_clk);
            check("path", {path_state, s_path}, {st, 2'h0});
            check("ports", {sel_1, sel_2, term_1, term_2}, {st == 2'h1, st == 2'h2, st != 2'h1, st != 2'h2});
        end
    end
endtask
task t_join;
    begin
        send(3'h1, 5'h00, 2'h0);
        repeat (150) @(negedge core_clk);
        check("unlinked", {s_addr, rx_count}, {5'h1f, 8'h00});
        @(posedge core_clk);
        linked <= 1'b1;
    end
endtask
task t_refresh(input [7:0] n, input [1:0] keep);
    begin
        send(3'h1, 5'h00, 2'h0);
        wait_frame(n);
        check("start", rx_frame[15], 1'b0);
        check("op", rx_frame[14:12], 3'h1);
        check("offer", rx_frame[11:7], 5'h02);
        check("slave addr", {s_master, s_addr}, {1'b0, 5'h01});
        check("kept", path_state, keep);
        check("count", chain_count_r, 5'h01);
    end
endtask
task t_forward;
    begin
        send(3'h2, 5'h01, 2'h2);
        repeat (150) @(negedge core_clk);
        check("slave path", {s_path, rx_count, path_state}, {2'h2, 8'h02, 2'h1});
        send(3'h2, 5'h05, 2'h2);
        wait_frame(8'h03);
        check("fwd", {rx_frame[14:5]}, {3'h2, 5'h05, 2'h2});
        check("local", path_state, 2'h1);
        send(3'h2, 5'h18, 2'h1);
        wait_frame(8'h04);
        check("last", rx_frame[11:7], 5'h18);
        send(3'h2, 5'h19, 2'h2);
        repeat (100) @(negedge core_clk);
        check("drop", rx_count, 8'h04);
    end
endtask
initial begin
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check("idle", {ser_out_r, host_ready, my_addr_r, path_state, term_1, term_2},
        {1'b1, 1'b0, 5'h1f, 2'h0, 1'b1, 1'b1});
    @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(negedge core_clk);
    check("master", {is_master_r, my_addr_r}, {1'b1, 5'h00});
    check("slave idle", {s_master, s_ready, s_ser, s_addr}, {1'b0, 1'b0, 1'b1, 5'h1f});
    t_paths;
    t_join;
    t_refresh(8'h01, 2'h0);
    send(3'h2, 5'h00, 2'h1);
    t_refresh(8'h02, 2'h1);
    t_forward;
    report_and_stop;
end
endmodule
